/* File: include/dtd_consts.svh */
/*
 Constants of the dual tone digit codec: offsets, fields, timing.
 Assumes a 50 MHz pclk; all tone timing derives from it.
*/
// Overview of operation
// - Classify tones by counting comparator periods
// - Early steer follows valid pair, drops one cycle after loss
// - Fixed digit code table, rows and columns
// - Steer threshold after guard latches code
// - Guard output driven while early steer high and state not idle
// - Delayed steering flag after settle, in status
// - Interrupt mode pulls pin low on flag
// - Receive latch updates on flag rise only
// - External guard filters dropouts and short tones
// - Steer below threshold frees the receiver
// - Call-progress mode blocks digit decoding
// - Call-progress square wave on interrupt pin
// - Pin is open drain, wave needs enable
// - Transmit write latches code, picks dividers
// - Thirty-two segments per tone period
// - Segment counter addresses sine table, two channels
// - Tones derive from the free running clock
`ifndef DTD_CONSTS_SVH
`define DTD_CONSTS_SVH
// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define DTD_OFF_CTRL 8'h00
`define DTD_OFF_TX 8'h04
`define DTD_OFF_RX 8'h08
`define DTD_OFF_STAT 8'h0c
`define DTD_CTRL_RST 3'h0
`define DTD_MID 8'h80
// ----------------------------------------
// Timing
// ----------------------------------------
`define DTD_CLK_HZ 50000000
`define DTD_CLK_MHZ 50
`define DTD_SEGS 32
`define DTD_SETTLE_NS 100
`define DTD_SETTLE_CYC ((`DTD_SETTLE_NS * `DTD_CLK_MHZ + 999) / 1000)
`define DTD_PER(f) (`DTD_CLK_HZ / (f))
`define DTD_DIV(f) ((`DTD_CLK_HZ + 16 * (f)) / (`DTD_SEGS * (f)) - 1)
`endif

/* File: include/dtd_pkg.sv */
/*
 Types of the dual tone digit codec.
 Assumes dtd_consts.svh supplies the numbers.
*/
package dtd_pkg;
  // Control register fields
  typedef struct packed {
    logic irq_en;
    logic cp_mode;
    logic tone_en;
  } dtd_ctrl_t;
  // Row and column index pair
  typedef struct packed {
    logic [1:0] row;
    logic [1:0] col;
  } dtd_pair_t;
  // Steering sequence
  typedef enum logic [1:0] {st_idle, st_settle, st_valid} dtd_steer_t;
endpackage : dtd_pkg

/* File: rtl/dtd_codec.sv */
/*
 Digital core of a dual tone digit transceiver with an APB slave.
 Assumes comparator and steering inputs are asynchronous pins and
 the tone samples feed an external converter.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dtd_consts.svh"
module dtd_codec #(
  // Divider reloads, row then column, for 32 segments per period
  parameter logic [11:0] DIV_R0 = 12'(`DTD_DIV(697)),
  parameter logic [11:0] DIV_R1 = 12'(`DTD_DIV(770)),
  parameter logic [11:0] DIV_R2 = 12'(`DTD_DIV(852)),
  parameter logic [11:0] DIV_R3 = 12'(`DTD_DIV(941)),
  parameter logic [11:0] DIV_C0 = 12'(`DTD_DIV(1209)),
  parameter logic [11:0] DIV_C1 = 12'(`DTD_DIV(1336)),
  parameter logic [11:0] DIV_C2 = 12'(`DTD_DIV(1477)),
  parameter logic [11:0] DIV_C3 = 12'(`DTD_DIV(1633))
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_tone_in,
  input wire logic high_tone_in,
  input wire logic progress_tone_in,
  input wire logic steer_guard_pin_i,
  output logic steer_guard_pin_o,
  output logic steer_guard_pin_oe_n,
  output logic early_steer_out,
  output logic interrupt_or_progress_out,
  output logic interrupt_or_progress_oe_n,
  output logic [7:0] row_sample,
  output logic [7:0] col_sample
);
  localparam int SETTLE_I = `DTD_SETTLE_CYC;
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Digit code of a row and column index
  function automatic logic [3:0] code_of(logic [1:0] r, logic [1:0] c);
    logic [3:0] v;
    v = 4'h0;
    if (c == 2'd3) begin
      v = (r == 2'd3) ? 4'h0 : 4'(4'hd + r);
    end else if (r != 2'd3) begin
      v = 4'(r * 3 + c + 1);
    end else begin
      v = (c == 2'd0) ? 4'hb : (c == 2'd1) ? 4'ha : 4'hc;
    end
    return v;
  endfunction : code_of
  // Nominal period in clocks of each group frequency
  function automatic logic [16:0] nom_per(logic hi, logic [1:0] k);
    logic [16:0] p;
    unique case ({hi, k})
      3'h0: p = 17'(`DTD_PER(697));
      3'h1: p = 17'(`DTD_PER(770));
      3'h2: p = 17'(`DTD_PER(852));
      3'h3: p = 17'(`DTD_PER(941));
      3'h4: p = 17'(`DTD_PER(1209));
      3'h5: p = 17'(`DTD_PER(1336));
      3'h6: p = 17'(`DTD_PER(1477));
      3'h7: p = 17'(`DTD_PER(1633));
    endcase
    return p;
  endfunction : nom_per
  // Period to {valid, index}, about three percent window
  function automatic logic [2:0] classify(logic [16:0] per, logic hi);
    logic [2:0] r;
    logic [16:0] p;
    r = 3'h0;
    for (int k = 0; k < 4; k++) begin
      p = nom_per(hi, 2'(k));
      if (per >= p - (p >> 5) && per <= p + (p >> 5)) begin
        r = {1'b1, 2'(k)};
      end
    end
    return r;
  endfunction : classify
  // Quarter wave sine, 32 phases around midscale
  function automatic logic [7:0] sine(logic [4:0] ph);
    logic [3:0] i;
    logic [6:0] a;
    i = ph[3] ? 4'(5'd16 - {2'b0, ph[3:0]}) : {1'b0, ph[2:0]};
    i = ph[3] ? 4'(8 - {1'b0, ph[2:0]}) : i;
    unique case (i)
      4'h0: a = 7'd0;
      4'h1: a = 7'd25;
      4'h2: a = 7'd49;
      4'h3: a = 7'd71;
      4'h4: a = 7'd90;
      4'h5: a = 7'd106;
      4'h6: a = 7'd117;
      4'h7: a = 7'd125;
      default: a = 7'd127;
    endcase
    return ph[4] ? 8'(`DTD_MID - a) : 8'(`DTD_MID + a);
  endfunction : sine
  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  dtd_pkg::dtd_ctrl_t ctrl_q; // Mode and enables
  logic [3:0] tx_code_q; // Transmit digit
  logic [3:0] rx_data_q; // Receive output latch
  logic [3:0] pend_q; // Code caught at registration
  dtd_pkg::dtd_steer_t state_q;
  logic est_q;
  logic setup;
  logic hit;
  assign setup = psel & ~penable & ~pready;
  assign hit = paddr == `DTD_OFF_CTRL || paddr == `DTD_OFF_TX ||
               paddr == `DTD_OFF_RX || paddr == `DTD_OFF_STAT;
  // Answer one cycle after setup, so access has one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit; // Unmapped address errors
      prdata <= 32'h0;
      if (setup && !pwrite) begin
        unique case (paddr)
          `DTD_OFF_CTRL: prdata <= {29'h0, ctrl_q};
          `DTD_OFF_TX: prdata <= {28'h0, tx_code_q};
          `DTD_OFF_RX: prdata <= {28'h0, rx_data_q};
          `DTD_OFF_STAT: prdata <= {28'h0, state_q != dtd_pkg::st_idle,
            ctrl_q.tone_en, est_q, state_q == dtd_pkg::st_valid};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
  // Writes take effect at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `DTD_CTRL_RST;
      tx_code_q <= 4'h0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == `DTD_OFF_CTRL) begin
        ctrl_q <= pwdata[2:0];
      end
      if (paddr == `DTD_OFF_TX) begin
        tx_code_q <= pwdata[3:0];
      end
    end
  end
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [3:0] s1_q; // First stage, read only by s2_q
  logic [3:0] s2_q; // {progress, steer, high, low}
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
    end else begin
      s1_q <= {progress_tone_in, steer_guard_pin_i, high_tone_in, low_tone_in};
      s2_q <= s1_q;
    end
  end
  // ----------------------------------------
  // Tone period counters, one per group
  // ----------------------------------------
  logic [1:0] grp_ok;
  logic [1:0] grp_idx [2];
  for (genvar g = 0; g < 2; g++) begin : g_rx
    logic prev_q;
    logic [16:0] cnt_q;
    logic [2:0] last_q;
    logic [2:0] cls;
    assign cls = classify(cnt_q, 1'(g));
    // Two matching periods in a row make a group valid; a voice-like
    // signal wanders and fails the match
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prev_q <= 1'b0;
        cnt_q <= 17'h0;
        last_q <= 3'h0;
        grp_ok[g] <= 1'b0;
        grp_idx[g] <= 2'h0;
      end else begin
        prev_q <= s2_q[g];
        if (s2_q[g] && !prev_q) begin
          cnt_q <= 17'h1;
          last_q <= cls;
          grp_ok[g] <= cls[2] && cls == last_q;
          grp_idx[g] <= cls[1:0];
        end else if (cnt_q == 17'h1ffff) begin
          grp_ok[g] <= 1'b0; // Signal stopped
        end else begin
          cnt_q <= cnt_q + 17'h1;
          if (cnt_q > nom_per(1'(g), 2'h0) + (nom_per(1'(g), 2'h0) >> 5)) begin
            grp_ok[g] <= 1'b0;
          end
        end
      end
    end
  end
  // ----------------------------------------
  // Early steering and steering sequence
  // ----------------------------------------
  logic both;
  logic [3:0] cnt_s_q;
  assign both = &grp_ok & ~ctrl_q.cp_mode;
  // Early steer drops in the cycle after the pair is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      est_q <= 1'b0;
    end else begin
      est_q <= both;
    end
  end
  // Guard times come from the external RC seen on the steer pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= dtd_pkg::st_idle;
      pend_q <= 4'h0;
      rx_data_q <= 4'h0;
      cnt_s_q <= 4'h0;
    end else if (!s2_q[2]) begin
      state_q <= dtd_pkg::st_idle;
    end else begin
      unique case (state_q)
        dtd_pkg::st_idle: begin
          if (est_q) begin
            state_q <= dtd_pkg::st_settle;
            pend_q <= code_of(grp_idx[0], grp_idx[1]);
            cnt_s_q <= 4'h1;
          end
        end
        dtd_pkg::st_settle: begin
          cnt_s_q <= cnt_s_q + 4'h1;
          if (cnt_s_q == 4'(SETTLE_I)) begin
            state_q <= dtd_pkg::st_valid;
            rx_data_q <= pend_q;
          end
        end
        dtd_pkg::st_valid: state_q <= dtd_pkg::st_valid;
      endcase
    end
  end
  // ----------------------------------------
  // Pins: guard drive and interrupt
  // ----------------------------------------
  // Guard drive holds the RC high; released it lets the RC fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steer_guard_pin_o <= 1'b0;
      steer_guard_pin_oe_n <= 1'b1;
      early_steer_out <= 1'b0;
      interrupt_or_progress_out <= 1'b0;
      interrupt_or_progress_oe_n <= 1'b1;
    end else begin
      steer_guard_pin_o <= 1'b1;
      steer_guard_pin_oe_n <= ~(both && state_q != dtd_pkg::st_idle);
      early_steer_out <= both;
      interrupt_or_progress_out <= 1'b0;
      if (!ctrl_q.irq_en) begin
        interrupt_or_progress_oe_n <= 1'b1;
      end else if (ctrl_q.cp_mode) begin
        interrupt_or_progress_oe_n <= s2_q[3];
      end else begin
        interrupt_or_progress_oe_n <= state_q != dtd_pkg::st_valid;
      end
    end
  end
  // ----------------------------------------
  // Tone synthesizers, row and column
  // ----------------------------------------
  dtd_pkg::dtd_pair_t txp;
  logic [11:0] rel [2];
  logic [7:0] smp [2];
  logic [4:0] seg [2];
  // Search the same table the receiver uses, a 2-of-8 pick
  always_comb begin
    txp = '0;
    for (int i = 0; i < 16; i++) begin
      if (code_of(2'(i >> 2), 2'(i)) == tx_code_q) begin
        txp = 4'(i);
      end
    end
    rel[0] = txp.row[1] ? (txp.row[0] ? DIV_R3 : DIV_R2) :
             (txp.row[0] ? DIV_R1 : DIV_R0);
    rel[1] = txp.col[1] ? (txp.col[0] ? DIV_C3 : DIV_C2) :
             (txp.col[0] ? DIV_C1 : DIV_C0);
  end
  for (genvar g = 0; g < 2; g++) begin : g_tx
    logic [11:0] div_q;
    // Runs off the always running pclk, no start-up wait
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        div_q <= 12'h0;
        seg[g] <= 5'h0;
        smp[g] <= `DTD_MID;
      end else if (!ctrl_q.tone_en) begin
        div_q <= 12'h0;
        seg[g] <= 5'h0;
        smp[g] <= `DTD_MID;
      end else begin
        smp[g] <= sine(seg[g]);
        if (div_q >= rel[g]) begin
          div_q <= 12'h0;
          seg[g] <= seg[g] + 5'h1;
        end else begin
          div_q <= div_q + 12'h1;
        end
      end
    end
  end
  assign row_sample = smp[0];
  assign col_sample = smp[1];
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_settle;
    state_q == dtd_pkg::st_settle && s2_q[2];
  endsequence
  property p_cp_blocks;
    ctrl_q.cp_mode |=> !early_steer_out;
  endproperty
  a_cp_blocks: assert property (p_cp_blocks) else $error("decode in cp mode");
  property p_est_drop;
    !(&grp_ok) |=> !early_steer_out;
  endproperty
  a_est_drop: assert property (p_est_drop) else $error("early steer held");
  property p_latch;
    state_q == dtd_pkg::st_idle && est_q && s2_q[2] |=>
      s_settle and pend_q == $past(code_of(grp_idx[0], grp_idx[1]));
  endproperty
  a_latch: assert property (p_latch) else $error("code not latched");
  property p_guard;
    both && state_q == dtd_pkg::st_settle |=> !steer_guard_pin_oe_n;
  endproperty
  a_guard: assert property (p_guard) else $error("guard not driven");
  property p_flag;
    $rose(state_q == dtd_pkg::st_settle) |-> ##[1:SETTLE_I]
      (state_q == dtd_pkg::st_valid || !s2_q[2]);
  endproperty
  a_flag: assert property (p_flag) else $error("flag late");
  property p_irq;
    state_q == dtd_pkg::st_valid && ctrl_q.irq_en && !ctrl_q.cp_mode |=>
      !interrupt_or_progress_oe_n && !interrupt_or_progress_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not pulled");
  property p_rx_hold;
    !(state_q == dtd_pkg::st_settle) |=> $stable(rx_data_q);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx changed");
  property p_free;
    !s2_q[2] |=> state_q == dtd_pkg::st_idle;
  endproperty
  a_free: assert property (p_free) else $error("not freed");
  property p_cp_wave;
    ctrl_q.cp_mode && ctrl_q.irq_en ##1 ctrl_q.cp_mode && ctrl_q.irq_en |->
      interrupt_or_progress_oe_n == $past(s2_q[3]);
  endproperty
  a_cp_wave: assert property (p_cp_wave) else $error("cp wave wrong");
  property p_mid;
    !ctrl_q.tone_en |=> row_sample == `DTD_MID && col_sample == `DTD_MID;
  endproperty
  a_mid: assert property (p_mid) else $error("not midscale");
endmodule : dtd_codec
`default_nettype wire

/* File: verification/dtd_line_model.sv */
/*
 Line side model: comparator square waves of both tone groups and the
 external steering RC.
 Assumes one pclk domain and the codec's split steer pin.
*/
`timescale 1ns/1ps
`default_nettype none
module dtd_line_model #(
  parameter int GUARD_CYC = 64 // Charge level standing for the steer threshold
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] low_half, // Half period in cycles, zero keeps silent
  input wire logic [15:0] high_half, // Half period in cycles, zero keeps silent
  input wire logic early_steer_out,
  input wire logic steer_guard_pin_o,
  input wire logic steer_guard_pin_oe_n,
  output logic low_tone_in,
  output logic high_tone_in,
  output logic steer_guard_pin_i
);
  logic [15:0] low_cnt_q; // Cycles into the low group half period
  logic [15:0] high_cnt_q; // Cycles into the high group half period
  logic [7:0] cap_q; // Capacitor charge, all ones is full rail
  // ----------------------------------------
  // Tone sources
  // ----------------------------------------
  // A shortened half period takes effect at once, so a bad period can be forced
  // Comparators rest high, so the first rising edge comes a full period after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_q <= 16'h0000;
      low_tone_in <= 1'b1;
    end else if (low_half == 16'h0000) begin
      low_cnt_q <= 16'h0000;
    end else if (low_cnt_q >= low_half - 16'h0001) begin
      low_cnt_q <= 16'h0000;
      low_tone_in <= !low_tone_in;
    end else begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end
  // High group source, same scheme
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_cnt_q <= 16'h0000;
      high_tone_in <= 1'b1;
    end else if (high_half == 16'h0000) begin
      high_cnt_q <= 16'h0000;
    end else if (high_cnt_q >= high_half - 16'h0001) begin
      high_cnt_q <= 16'h0000;
      high_tone_in <= !high_tone_in;
    end else begin
      high_cnt_q <= high_cnt_q + 16'h0001;
    end
  end
  // ----------------------------------------
  // Steering RC
  // ----------------------------------------
  // Charges while early steer is high, slams to rail under guard drive, else decays
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q <= 8'h00;
    end else if (!steer_guard_pin_oe_n && steer_guard_pin_o) begin
      cap_q <= 8'hff;
    end else if (early_steer_out && cap_q != 8'hff) begin
      cap_q <= cap_q + 8'h01;
    end else if (!early_steer_out && cap_q != 8'h00) begin
      cap_q <= cap_q - 8'h01;
    end
  end
  // Wire level: the guard drive wins, otherwise the comparator on the cap
  assign steer_guard_pin_i = !steer_guard_pin_oe_n ? steer_guard_pin_o :
                             (cap_q >= 8'(GUARD_CYC));
endmodule : dtd_line_model
`default_nettype wire

/* File: verification/tb_top.sv */
/*
 Self-checking bench of the dual tone digit codec over APB.
 Assumes the codec, its package and the line side model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dtd_consts.svh"
// Compare, count and report one value
`define TB_CMP(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic low_tone_in, high_tone_in, steer_guard_pin_i, steer_guard_pin_o;
  logic progress_tone_in = 1'b0;
  logic steer_guard_pin_oe_n, early_steer_out;
  logic interrupt_or_progress_out, interrupt_or_progress_oe_n;
  logic [7:0] row_sample, col_sample;
  logic [15:0] low_half = 16'h67c7; // Star pair from the start: 941 Hz row
  logic [15:0] high_half = 16'h50c6; // 1209 Hz column
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0; // Cycle count for the hang limit
  // Digit codes with their row and column tones
  logic [3:0] codes [4] = '{4'h1, 4'h5, 4'h9, 4'h0};
  int rows [4] = '{697, 770, 852, 941};
  int cols [4] = '{1209, 1336, 1477, 1633};
  // ----------------------------------------
  // Clock, hang limit, instances
  // ----------------------------------------
  always #10 pclk = !pclk;
  // The pair needs two row periods from reset, about 106k cycles; the rest is short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 130000) begin
      n_mismatch++;
      conclude();
    end
  end
  dtd_codec i_dtd_codec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_tone_in(low_tone_in), .high_tone_in(high_tone_in),
    .progress_tone_in(progress_tone_in), .steer_guard_pin_i(steer_guard_pin_i),
    .steer_guard_pin_o(steer_guard_pin_o), .steer_guard_pin_oe_n(steer_guard_pin_oe_n),
    .early_steer_out(early_steer_out), .interrupt_or_progress_out(interrupt_or_progress_out),
    .interrupt_or_progress_oe_n(interrupt_or_progress_oe_n), .row_sample(row_sample),
    .col_sample(col_sample));
  dtd_line_model i_dtd_line_model (.pclk(pclk), .presetn(presetn), .low_half(low_half),
    .high_half(high_half), .early_steer_out(early_steer_out),
    .steer_guard_pin_o(steer_guard_pin_o), .steer_guard_pin_oe_n(steer_guard_pin_oe_n),
    .low_tone_in(low_tone_in), .high_tone_in(high_tone_in),
    .steer_guard_pin_i(steer_guard_pin_i));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // One APB transfer; entered just after a rising edge, leaves one edge after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No wait count of its own: only the hang limit ends a stuck transfer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Bounded wait for a level, then compare it
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      n++;
      @(posedge pclk);
    end
    `TB_CMP("awaited level", v, s)
  endtask : wait_lvl
  // Cycles between two sample changes; the first change aligns to a segment edge
  task automatic seg_len(input logic col, output int d);
    logic [7:0] last;
    int n;
    last = col ? col_sample : row_sample;
    d = 0;
    n = 0;
    while (n < 2 && d < 20000) begin
      @(posedge pclk);
      d++;
      if ((col ? col_sample : row_sample) !== last) begin
        n++;
        if (n == 1) d = 0;
        last = col ? col_sample : row_sample;
      end
    end
  endtask : seg_len
  // Thirty-two segments must span the tone period within one percent
  function automatic logic near(input int d, input int f);
    longint e;
    e = longint'(32) * d * f - 50000000;
    if (e < 0) e = -e;
    return (e * 100 <= 50000000);
  endfunction : near
  // Counts, verdict and end of run
  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] rd;
    logic err;
    int rlen, clen;
    repeat (6) @(posedge pclk);
    `TB_CMP("early steer in reset", 1'b0, early_steer_out)
    `TB_CMP("row rest in reset", `DTD_MID, row_sample)
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values of all four registers, then a refused address
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0, rd, err);
      `TB_CMP("reset value", 32'h0, rd)
    end
    apb(1'b0, 8'h10, 32'h0, rd, err);
    `TB_CMP("unmapped error", 1'b1, err)
    `TB_CMP("unmapped data", 32'h0, rd)
    // Receive register is read only
    apb(1'b1, `DTD_OFF_RX, 32'h5, rd, err);
    apb(1'b0, `DTD_OFF_RX, 32'h0, rd, err);
    `TB_CMP("rx read only", 4'h0, rd[3:0])
    // Transmit sweep covering every row and every column
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `DTD_OFF_TX, 32'(codes[k]), rd, err);
      repeat (3) @(posedge pclk);
      `TB_CMP("row rest while off", `DTD_MID, row_sample)
      `TB_CMP("col rest while off", `DTD_MID, col_sample)
      apb(1'b1, `DTD_OFF_CTRL, 32'h1, rd, err);
      fork
        seg_len(1'b0, rlen);
        seg_len(1'b1, clen);
      join
      `TB_CMP("row segment", 1'b1, near(rlen, rows[k]))
      `TB_CMP("col segment", 1'b1, near(clen, cols[k]))
      apb(1'b1, `DTD_OFF_CTRL, 32'h0, rd, err);
    end
    // Receive the star pair that has been on the line since reset, interrupts on
    apb(1'b1, `DTD_OFF_CTRL, 32'h4, rd, err);
    wait_lvl(early_steer_out, 1'b1, 120000);
    wait_lvl(interrupt_or_progress_oe_n, 1'b0, 2000);
    `TB_CMP("guard drive", 1'b0, steer_guard_pin_oe_n)
    `TB_CMP("guard level", 1'b1, steer_guard_pin_o)
    apb(1'b0, `DTD_OFF_STAT, 32'h0, rd, err);
    `TB_CMP("status registered", 4'hb, rd[3:0])
    apb(1'b0, `DTD_OFF_RX, 32'h0, rd, err);
    `TB_CMP("rx star code", 4'hb, rd[3:0])
    // Call-progress mode hides the valid pair; back in tone mode it shows again
    apb(1'b1, `DTD_OFF_CTRL, 32'h6, rd, err);
    wait_lvl(early_steer_out, 1'b0, 4);
    apb(1'b1, `DTD_OFF_CTRL, 32'h4, rd, err);
    wait_lvl(early_steer_out, 1'b1, 8);
    // A row period far out of band must drop early steer
    low_half <= 16'h03e8;
    wait_lvl(early_steer_out, 1'b0, 60000);
    repeat (3) @(posedge pclk);
    `TB_CMP("guard released", 1'b1, steer_guard_pin_oe_n)
    wait_lvl(interrupt_or_progress_oe_n, 1'b1, 2000);
    apb(1'b0, `DTD_OFF_STAT, 32'h0, rd, err);
    `TB_CMP("flag and state clear", 2'h0, {rd[3], rd[0]})
    apb(1'b0, `DTD_OFF_RX, 32'h0, rd, err);
    `TB_CMP("rx holds code", 4'hb, rd[3:0])
    low_half <= 16'h0000;
    high_half <= 16'h0000;
    // Call progress square wave, with and without interrupt enable
    apb(1'b1, `DTD_OFF_CTRL, 32'h6, rd, err);
    repeat (6) @(posedge pclk);
    `TB_CMP("progress low", 1'b0, interrupt_or_progress_oe_n)
    progress_tone_in <= 1'b1;
    repeat (6) @(posedge pclk);
    `TB_CMP("progress high", 1'b1, interrupt_or_progress_oe_n)
    apb(1'b1, `DTD_OFF_CTRL, 32'h2, rd, err);
    progress_tone_in <= 1'b0;
    repeat (6) @(posedge pclk);
    `TB_CMP("progress gated", 1'b1, interrupt_or_progress_oe_n)
    `TB_CMP("open drain level", 1'b0, interrupt_or_progress_out)
    conclude();
  end
endmodule : tb_top
`default_nettype wire
